// ### common/dcc_pkg.sv
// Shared constants for the converter clock configuration block
package dcc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] CFG_IDX = 8'h96;
    localparam logic [7:0] CTL_IDX = 8'h97;
    localparam int ADR_W = 12;
    localparam logic [ADR_W-1:0] CFG_ADDR = {2'h0, CFG_IDX, 2'h0};
    localparam logic [ADR_W-1:0] CTL_ADDR = {2'h0, CTL_IDX, 2'h0};
    // Configuration register fields
    localparam int CFG_RSVD_BIT = 7;
    localparam int CFG_DIV_HI = 6;
    localparam int CFG_DIV_LO = 5;
    localparam int CFG_SARPOL_BIT = 4;
    localparam int CFG_CONVERTER_CLOCK_INVERT_BIT = 3;
    localparam int CFG_ILIM_BIT = 2;
    localparam int CFG_SLP_BIT = 1;
    localparam int CFG_SRC_BIT = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Control register fields
    localparam int CTL_MINPW_HI = 7;
    localparam int CTL_MINPW_LO = 6;
    localparam int CTL_SWSEL_BIT = 5;
    localparam int CTL_RSVD_BIT = 4;
    localparam int CTL_SYNC_BIT = 3;
    localparam int CTL_VSEL_HI = 2;
    localparam int CTL_VSEL_LO = 0;
    localparam logic [7:0] CTL_RESET = 8'h21;
    // Divider
    localparam int DIV_CODE_W = 2;
    localparam int DIV_CNT_W = 3;
    localparam logic [DIV_CODE_W-1:0] DIV_CODE_MAX = 2'h3;
    // System clock
    localparam int CLK_PERIOD_NS = 50;
endpackage : dcc_pkg

// ### hw/dcc_clk_div.sv
// Divide-by-1/2/4/8 tick generator for the converter clock
`timescale 1ns/1ns
module dcc_clk_div #(
    parameter int CODE_W = dcc_pkg::DIV_CODE_W,
    parameter int CNT_W = dcc_pkg::DIV_CNT_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic restart_i,
    input wire logic [CODE_W-1:0] code_i,
    output logic tick_o
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] limit;

    always_comb begin
        limit = CNT_W'((1 << code_i) - 1);
        tick_o = (cnt_q == limit) && !restart_i;
        if (restart_i || tick_o) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : dcc_clk_div

// ### hw/dcc_clock_config.sv
// Converter clock configuration registers with clock divider and sync control
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ns
module dcc_clock_config (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [dcc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic switch_quiet_i,
    output logic conv_clk_src_sys_o,
    output logic conv_clk_en_o,
    output logic conv_clk_invert_o,
    output logic sar_clk_en_o,
    output logic sar_clk_invert_o,
    output logic adc_track_o,
    output logic sync_enable_o,
    output logic peak_current_high_o,
    output logic sleep_supply_float_o,
    output logic switch_small_o,
    output logic [1:0] min_pulse_sel_o,
    output logic [2:0] out_voltage_sel_o
);
    // Register file
    logic [6:0] cfg_q;
    logic [6:0] cfg_d;
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic ack_q;
    logic ack_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic req;

    always_comb begin
        req = wb_cyc_i && wb_stb_i && !ack_q;
        ack_d = req;
        cfg_d = cfg_q;
        ctl_d = ctl_q;
        rdat_d = rdat_q;
        if (req && !wb_we_i) begin
            rdat_d = 32'h0000_0000;
            if (wb_adr_i == dcc_pkg::CFG_ADDR) begin
                rdat_d = {25'h0, cfg_q};
            end else if (wb_adr_i == dcc_pkg::CTL_ADDR) begin
                rdat_d = {24'h0, ctl_q};
                rdat_d[dcc_pkg::CTL_RSVD_BIT] = 1'b0;
            end
        end
        if (req && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == dcc_pkg::CFG_ADDR) begin
                // Bit 7 is not stored, so a stray one is dropped
                cfg_d = wb_dat_i[6:0];
            end else if (wb_adr_i == dcc_pkg::CTL_ADDR) begin
                ctl_d = wb_dat_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= dcc_pkg::CFG_RESET[6:0];
            ctl_q <= dcc_pkg::CTL_RESET;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            cfg_q <= cfg_d;
            ctl_q <= ctl_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // Quiet-time pin from the power stage crosses in through two flops
    logic quiet_s1_q;
    logic quiet_s2_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            quiet_s1_q <= 1'b0;
            quiet_s2_q <= 1'b0;
        end else begin
            quiet_s1_q <= switch_quiet_i;
            quiet_s2_q <= quiet_s1_q;
        end
    end

    // Active clock settings: taken over at a period boundary on the system clock and at once on the local oscillator, so no
    // converter clock period is ever cut short by a register write
    logic src_act_q;
    logic src_act_d;
    logic inv_act_q;
    logic inv_act_d;
    logic [1:0] div_act_q;
    logic [1:0] div_act_d;
    logic restart;
    logic tick;
    logic src_sel;
    logic [1:0] div_sel;

    always_comb begin
        src_sel = cfg_q[dcc_pkg::CFG_SRC_BIT];
        div_sel = cfg_q[dcc_pkg::CFG_DIV_HI:dcc_pkg::CFG_DIV_LO];
        src_act_d = src_act_q;
        inv_act_d = inv_act_q;
        div_act_d = div_act_q;
        restart = 1'b0;
        if (!src_act_q) begin
            // Local oscillator: no system pulses in flight, apply at once
            src_act_d = src_sel;
            inv_act_d = cfg_q[dcc_pkg::CFG_CONVERTER_CLOCK_INVERT_BIT];
            div_act_d = div_sel;
            restart = 1'b1;
        end else if (tick) begin
            src_act_d = src_sel;
            inv_act_d = cfg_q[dcc_pkg::CFG_CONVERTER_CLOCK_INVERT_BIT];
            div_act_d = div_sel;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_act_q <= dcc_pkg::CFG_RESET[dcc_pkg::CFG_SRC_BIT];
            inv_act_q <= dcc_pkg::CFG_RESET[dcc_pkg::CFG_CONVERTER_CLOCK_INVERT_BIT];
            div_act_q <= dcc_pkg::CFG_RESET[dcc_pkg::CFG_DIV_HI:dcc_pkg::CFG_DIV_LO];
        end else begin
            src_act_q <= src_act_d;
            inv_act_q <= inv_act_d;
            div_act_q <= div_act_d;
        end
    end

    dcc_clk_div #(
        .CODE_W(dcc_pkg::DIV_CODE_W),
        .CNT_W(dcc_pkg::DIV_CNT_W)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(restart),
        .code_i(div_act_q),
        .tick_o(tick)
    );

    // Registered outputs
    logic en_q;
    logic en_d;
    logic cinv_q;
    logic cinv_d;
    logic csrc_q;
    logic csrc_d;
    logic sar_en_q;
    logic sar_en_d;
    logic sar_inv_q;
    logic sar_inv_d;
    logic track_q;
    logic track_d;
    logic sync_en;

    always_comb begin
        sync_en = ctl_q[dcc_pkg::CTL_SYNC_BIT];
        csrc_d = src_act_q;
        // Ticks only while the system clock feeds the converter
        en_d = tick && src_act_q;
        cinv_d = inv_act_q && src_act_q;
        sar_en_d = sync_en && tick && src_act_q;
        // Polarity bit reads 0 as invert; meaningless without sync
        sar_inv_d = sync_en && !cfg_q[dcc_pkg::CFG_SARPOL_BIT];
        track_d = sync_en && quiet_s2_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q <= 1'b0;
            cinv_q <= 1'b0;
            csrc_q <= 1'b0;
            sar_en_q <= 1'b0;
            sar_inv_q <= 1'b0;
            track_q <= 1'b0;
        end else begin
            en_q <= en_d;
            cinv_q <= cinv_d;
            csrc_q <= csrc_d;
            sar_en_q <= sar_en_d;
            sar_inv_q <= sar_inv_d;
            track_q <= track_d;
        end
    end

    assign conv_clk_en_o = en_q;
    assign conv_clk_invert_o = cinv_q;
    assign conv_clk_src_sys_o = csrc_q;
    assign sar_clk_en_o = sar_en_q;
    assign sar_clk_invert_o = sar_inv_q;
    assign adc_track_o = track_q;
    assign sync_enable_o = sync_en;
    assign peak_current_high_o = cfg_q[dcc_pkg::CFG_ILIM_BIT];
    assign sleep_supply_float_o = cfg_q[dcc_pkg::CFG_SLP_BIT];
    assign switch_small_o = ctl_q[dcc_pkg::CTL_SWSEL_BIT];
    assign min_pulse_sel_o = ctl_q[dcc_pkg::CTL_MINPW_HI:dcc_pkg::CTL_MINPW_LO];
    assign out_voltage_sel_o = ctl_q[dcc_pkg::CTL_VSEL_HI:dcc_pkg::CTL_VSEL_LO];

    // Helper: cycles since the last converter clock pulse
    logic [3:0] gap_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || en_q) begin
            gap_q <= 4'h0;
        end else if (gap_q != 4'hF) begin
            gap_q <= gap_q + 4'h1;
        end
    end

    sequence s_cfg_read;
        wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q && wb_adr_i == dcc_pkg::CFG_ADDR;
    endsequence

    sequence s_div8_tick;
        en_q && div_act_q == dcc_pkg::DIV_CODE_MAX && src_act_q;
    endsequence

    a_bit7_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        s_cfg_read |=> wb_ack_o && wb_dat_o[7] == 1'b0 && wb_dat_o[6:0] == $past(cfg_q))
        else $error("config read bit 7 not zero or data wrong");

    a_div8_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
        s_div8_tick ##1 (src_act_q && div_act_q == dcc_pkg::DIV_CODE_MAX)
            |-> !en_q [*7] ##1 en_q)
        else $error("divide by eight spacing wrong");

    a_div1_every: assert property (@(posedge clk_i) disable iff (rst_i)
        (src_act_q && div_act_q == 2'h0 && $past(src_act_q) && !restart) |=> en_q)
        else $error("divide by one missed a pulse");

    a_local_no_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        !src_act_q |=> !en_q && !sar_en_q)
        else $error("converter pulses while on local oscillator");

    a_sar_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
        (sync_en && !cfg_q[dcc_pkg::CFG_SARPOL_BIT]) |=> sar_clk_invert_o)
        else $error("SAR clock not inverted");

    a_sar_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        !sync_en |=> !sar_clk_invert_o && !sar_clk_en_o && !adc_track_o)
        else $error("SAR controls active without sync");

    a_clk_invert: assert property (@(posedge clk_i) disable iff (rst_i)
        (src_act_q && inv_act_q) |=> conv_clk_invert_o)
        else $error("divider input not inverted");

    a_static_fields: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0]
            && wb_adr_i == dcc_pkg::CFG_ADDR)
        |=> peak_current_high_o == $past(wb_dat_i[dcc_pkg::CFG_ILIM_BIT])
            && sleep_supply_float_o == $past(wb_dat_i[dcc_pkg::CFG_SLP_BIT]))
        else $error("static field output mismatch");

    a_source_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        (!src_act_q && src_sel) |=> ##1 conv_clk_src_sys_o)
        else $error("system clock source not taken");

    a_track_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (sync_en && quiet_s2_q) |=> adc_track_o)
        else $error("tracking not in quiet time");

    a_no_short_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        (src_act_q && $past(src_act_q) && $changed(div_act_q)) |-> $past(tick))
        else $error("divide ratio changed mid period");

    // Back to back pulses are only legal while dividing by one
    a_gap_held: assert property (@(posedge clk_i) disable iff (rst_i)
        (en_q && gap_q == 4'h0) |-> $past(div_act_q) == 2'h0)
        else $error("back to back pulses outside divide by one");

endmodule : dcc_clock_config

// ### testbench/dcc_stage_model.sv
// Behavioural power stage: reports a quiet window after each switching tick
`timescale 1ns/1ns
module dcc_stage_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic conv_clk_en_i,
    output logic switch_quiet_o
);
    logic [1:0] quiet_q;
    // Quiet for two cycles after each converter tick; the design resyncs it
    always @(posedge clk_i) begin
        if (rst_i) begin
            quiet_q <= 2'h0;
        end else if (conv_clk_en_i) begin
            quiet_q <= 2'h2;
        end else if (quiet_q != 2'h0) begin
            quiet_q <= quiet_q - 2'h1;
        end
    end
    assign switch_quiet_o = (quiet_q != 2'h0);
endmodule : dcc_stage_model

// ### testbench/tb.sv
// Self-checking bench for the converter clock configuration block
`timescale 1ns/1ns
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, src_sys, clk_en, clk_inv, sar_en, sar_inv, track, sync_en;
    logic pk_hi, slp_flt, sw_small, quiet;
    logic [1:0] minpw;
    logic [2:0] vsel;
    logic [7:0] rd;
    int miscompares = 0;
    int n_compared = 0;
    int n;

    always #25 clk_i = ~clk_i;

    dcc_clock_config dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .switch_quiet_i(quiet), .conv_clk_src_sys_o(src_sys),
        .conv_clk_en_o(clk_en), .conv_clk_invert_o(clk_inv), .sar_clk_en_o(sar_en),
        .sar_clk_invert_o(sar_inv), .adc_track_o(track), .sync_enable_o(sync_en),
        .peak_current_high_o(pk_hi), .sleep_supply_float_o(slp_flt),
        .switch_small_o(sw_small), .min_pulse_sel_o(minpw), .out_voltage_sel_o(vsel));

    dcc_stage_model stage (.clk_i(clk_i), .rst_i(rst_i), .conv_clk_en_i(clk_en),
        .switch_quiet_o(quiet));

    task automatic stop_test();
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Holds the request until ack is sampled high, then releases for a cycle
    task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 20);
        rd = rdat[7:0];
        chk("ack", {31'h0, ack}, 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    // Counts high cycles over 32 edges, a multiple of every divide ratio
    task automatic count(input int which, output int c);
        c = 0;
        repeat (32) begin
            @(posedge clk_i);
            case (which)
                0: c += (clk_en === 1'b1);
                1: c += (sar_en === 1'b1);
                default: c += (track === 1'b1);
            endcase
        end
    endtask : count

    task automatic t_reset();
        wb(1'b0, dcc_pkg::CFG_ADDR, 8'h00);
        chk("cfg_reset", rd, dcc_pkg::CFG_RESET);
        wb(1'b0, dcc_pkg::CTL_ADDR, 8'h00);
        chk("ctl_reset", rd, dcc_pkg::CTL_RESET);
        chk("swsel_reset", sw_small, 1'b1);
        chk("vsel_reset", vsel, 3'h1);
        chk("minpw_reset", minpw, 2'h0);
        chk("src_reset", src_sys, 1'b0);
        wb(1'b0, 12'h100, 8'h00);
        chk("unmapped", rd, 8'h00);
    endtask : t_reset

    task automatic t_fields();
        // Bit 7 is always written as zero
        wb(1'b1, dcc_pkg::CFG_ADDR, 8'h06);
        wb(1'b0, dcc_pkg::CFG_ADDR, 8'h00);
        chk("cfg_bit7", rd, 8'h06);
        chk("peak_hi", pk_hi, 1'b1);
        chk("slp_float", slp_flt, 1'b1);
        wb(1'b1, dcc_pkg::CFG_ADDR, 8'h00);
        chk("peak_lo", pk_hi, 1'b0);
        chk("slp_vbat", slp_flt, 1'b0);
    endtask : t_fields

    task automatic t_div();
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, dcc_pkg::CFG_ADDR, {1'b0, c[1:0], 1'b0, c[0], 3'b001});
            repeat (10) @(posedge clk_i);
            chk("src_sys", src_sys, 1'b1);
            chk("clk_inv", clk_inv, c[0]);
            count(0, n);
            chk("ticks", n, 32 >> c);
        end
    endtask : t_div

    task automatic t_local();
        // Leaving the system clock only waits for one tick of divide-by-8
        wb(1'b1, dcc_pkg::CFG_ADDR, 8'h68);
        repeat (12) @(posedge clk_i);
        chk("src_local", src_sys, 1'b0);
        chk("inv_local", clk_inv, 1'b0);
        count(0, n);
        chk("ticks_local", n, 0);
    endtask : t_local

    task automatic t_sync();
        wb(1'b1, dcc_pkg::CTL_ADDR, 8'h29);
        chk("sync_en", sync_en, 1'b1);
        for (int p = 0; p < 2; p++) begin
            wb(1'b1, dcc_pkg::CFG_ADDR, {3'b000, p[0], 4'b0001});
            repeat (10) @(posedge clk_i);
            chk("sar_inv", sar_inv, !p[0]);
            count(1, n);
            chk("sar_ticks", n, 32);
            count(2, n);
            chk("tracking", n > 0, 1'b1);
        end
        wb(1'b1, dcc_pkg::CFG_ADDR, 8'h01);
        wb(1'b1, dcc_pkg::CTL_ADDR, 8'h21);
        repeat (4) @(posedge clk_i);
        chk("sar_inv_off", sar_inv, 1'b0);
        count(1, n);
        chk("sar_off", n, 0);
        count(2, n);
        chk("track_off", n, 0);
        chk("sync_off", sync_en, 1'b0);
        wb(1'b1, dcc_pkg::CTL_ADDR, 8'hC6);
        wb(1'b0, dcc_pkg::CTL_ADDR, 8'h00);
        chk("ctl_rdback", rd, 8'hC6);
        chk("minpw", minpw, 2'h3);
        chk("swsel", sw_small, 1'b0);
        chk("vsel", vsel, 3'h6);
        wb(1'b1, dcc_pkg::CTL_ADDR, 8'h21);
    endtask : t_sync

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_fields();
        t_div();
        t_local();
        t_sync();
        stop_test();
    end

    initial begin
        #(50 * 5000);
        miscompares++;
        stop_test();
    end
endmodule : tb
